// [include/urc_pkg.sv]
package urc_pkg;

	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [7:0] URC_OFS_CTRL   = 8'h00;
	localparam logic [7:0] URC_OFS_STATUS = 8'h04;
	localparam logic [7:0] URC_OFS_IRQ    = 8'h08;
	localparam logic [7:0] URC_OFS_MASK   = 8'h0C;
	localparam logic [7:0] URC_OFS_LAST   = 8'h10;

	// control field positions
	localparam int URC_CTRL_ENABLE_A  = 0;
	localparam int URC_CTRL_BV_RISE    = 1;
	localparam int URC_CTRL_BV_FALL    = 2;
	localparam int URC_CTRL_DP_PD      = 3;
	localparam int URC_CTRL_DM_PD      = 4;
	localparam logic [4:0] URC_CTRL_RST = 5'h00;

	// interrupt bits
	localparam int URC_IRQ_SENT   = 0;
	localparam int URC_IRQ_ALT    = 1;
	localparam int URC_IRQ_RXERR  = 2;
	localparam int URC_IRQ_W      = 3;

	// status byte positions
	localparam int URC_BYTE_LINE = 0;
	localparam int URC_BYTE_VBUS = 2;
	localparam int URC_BYTE_EVT  = 4;
	localparam int URC_BYTE_ID   = 6;
	localparam int URC_BYTE_ALT  = 7;

	// bus voltage codes
	localparam logic [1:0] URC_VBUS_LOW   = 2'h0;
	localparam logic [1:0] URC_VBUS_END   = 2'h1;
	localparam logic [1:0] URC_VBUS_SESS  = 2'h2;
	localparam logic [1:0] URC_VBUS_AVLD  = 2'h3;

	// receive event codes
	localparam logic [1:0] URC_EVT_NONE   = 2'h0;
	localparam logic [1:0] URC_EVT_ACTIVE = 2'h1;
	localparam logic [1:0] URC_EVT_DISC   = 2'h2;
	localparam logic [1:0] URC_EVT_ERR    = 2'h3;

	// timing
	localparam int URC_CLK_HZ     = 10_000_000;
	localparam int URC_ID_WAIT_MS = 50;
	localparam int URC_ID_WAIT_CYC = URC_CLK_HZ / 1000 * URC_ID_WAIT_MS;

	// ------------------------------------------------------------
	// analog and receiver side inputs, link state encoding
	// ------------------------------------------------------------
	typedef struct packed {
		logic       sess_end;
		logic       sess_vld;
		logic       a_side_bus_valid_flag;
		logic       b_sess_vld;
		logic [1:0] line_state;
		logic       id_pin;
	} urc_analog_t;

	typedef struct packed {
		logic       receive_active_flag;
		logic       receive_error_flag;
		logic       host_disconnect_flag;
		logic       rx_data_valid;
		logic [7:0] rx_data;
	} urc_rx_t;

	typedef enum logic [1:0] {
		URC_ST_IDLE = 2'b00,
		URC_ST_TURN = 2'b01,
		URC_ST_SEND = 2'b10,
		URC_ST_DATA = 2'b11
	} urc_state_t;

endpackage : urc_pkg

// [src/urc_status.sv]
// The register addresses and the AHB-Lite register port were chosen for this implementation.
module urc_status
	import urc_pkg::*;
#(
	parameter int ID_WAIT_CYC = URC_ID_WAIT_CYC
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        clk_en,
	// analog and receiver side
	input  wire urc_analog_t analog_in,
	input  wire urc_rx_t     rx_in,
	// link pins
	output logic             dir,
	output logic             nxt,
	output logic [7:0]       data_out,
	output logic             data_oe,
	output logic             id_valid,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [7:0]  haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic [31:0]      hrdata,
	output logic             hreadyout,
	output logic             hresp,
	output logic             irq
);

	initial begin
		if (ID_WAIT_CYC < 1) $error("ID_WAIT_CYC must be at least one");
	end

	// ------------------------------------------------------------
	// input synchronisers
	// ------------------------------------------------------------
	// analog levels come from another domain, rx stream is same-clock
	urc_analog_t ana_m_q;
	urc_analog_t ana_q;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ana_m_q <= '0;
			ana_q   <= '0;
		end else if (clk_en) begin
			ana_m_q <= analog_in;
			ana_q   <= ana_m_q;
		end
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	logic [4:0]          ctrl_q;
	logic [URC_IRQ_W-1:0] irq_stat_q;
	logic [URC_IRQ_W-1:0] irq_mask_q;
	logic [URC_IRQ_W-1:0] irq_set;
	logic [7:0]          last_byte_q;
	logic                ph_valid_q;
	logic                ph_write_q;
	logic [7:0]          ph_addr_q;

	// address phase capture; single-cycle answer, always okay
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ph_valid_q <= 1'b0;
			ph_write_q <= 1'b0;
			ph_addr_q  <= 8'h00;
		end else if (clk_en && hready) begin
			ph_valid_q <= hsel && htrans[1];
			ph_write_q <= hwrite;
			ph_addr_q  <= haddr;
		end
	end

	// control register writes
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ctrl_q     <= URC_CTRL_RST;
			irq_mask_q <= '0;
		end else if (clk_en && ph_valid_q && ph_write_q) begin
			if (ph_addr_q == URC_OFS_CTRL) begin
				ctrl_q <= hwdata[4:0];
			end else if (ph_addr_q == URC_OFS_MASK) begin
				irq_mask_q <= hwdata[URC_IRQ_W-1:0];
			end
		end
	end

	// sticky status: set wins over write-one-to-clear
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			irq_stat_q <= '0;
		end else if (clk_en) begin
			if (ph_valid_q && ph_write_q && ph_addr_q == URC_OFS_IRQ) begin
				irq_stat_q <= (irq_stat_q & ~hwdata[URC_IRQ_W-1:0]) | irq_set;
			end else begin
				irq_stat_q <= irq_stat_q | irq_set;
			end
		end
	end

	// read data is registered at the address phase edge
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			hrdata <= 32'h0000_0000;
		end else if (clk_en && hready) begin
			if (!(hsel && htrans[1] && !hwrite)) begin
				hrdata <= 32'h0000_0000;
			end else if (haddr == URC_OFS_CTRL) begin
				hrdata <= {27'h0, ctrl_q};
			end else if (haddr == URC_OFS_STATUS) begin
				hrdata <= {26'h0, id_valid, ana_q.id_pin, ana_q.b_sess_vld,
					ana_q.a_side_bus_valid_flag, ana_q.sess_vld, ana_q.sess_end};
			end else if (haddr == URC_OFS_IRQ) begin
				hrdata <= {29'h0, irq_stat_q};
			end else if (haddr == URC_OFS_MASK) begin
				hrdata <= {29'h0, irq_mask_q};
			end else if (haddr == URC_OFS_LAST) begin
				hrdata <= {24'h0, last_byte_q};
			end else begin
				hrdata <= 32'h0000_0000;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			irq       <= 1'b0;
		end else if (clk_en) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			irq       <= |(irq_stat_q & irq_mask_q);
		end
	end

	// ------------------------------------------------------------
	// id settle timer
	// ------------------------------------------------------------
	// restarts whenever the pull-up is switched off
	logic [$clog2(ID_WAIT_CYC+1)-1:0] id_cnt_q;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			id_cnt_q <= '0;
			id_valid <= 1'b0;
		end else if (clk_en) begin
			if (!ctrl_q[URC_CTRL_ENABLE_A]) begin
				id_cnt_q <= '0;
				id_valid <= 1'b0;
			end else if (id_cnt_q != ID_WAIT_CYC[$bits(id_cnt_q)-1:0]) begin
				id_cnt_q <= id_cnt_q + 1'b1;
			end else begin
				id_valid <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// status byte assembly
	// ------------------------------------------------------------
	logic [1:0] vbus_code;
	logic [1:0] evt_code;
	logic       host_mode;
	logic       bv_prev_q;
	logic       alt_pend_q;
	logic       bv_edge;
	logic [7:0] cur_byte;

	// priority top-down so don't-care comparators cannot disturb the code
	always_comb begin
		if (ana_q.a_side_bus_valid_flag) begin
			vbus_code = URC_VBUS_AVLD;
		end else if (ana_q.sess_vld) begin
			vbus_code = URC_VBUS_SESS;
		end else if (!ana_q.sess_end) begin
			vbus_code = URC_VBUS_END;
		end else begin
			vbus_code = URC_VBUS_LOW;
		end
	end

	assign host_mode = ctrl_q[URC_CTRL_DP_PD] && ctrl_q[URC_CTRL_DM_PD];

	// receive events outrank disconnect, which only counts as host
	always_comb begin
		if (rx_in.receive_active_flag && rx_in.receive_error_flag) begin
			evt_code = URC_EVT_ERR;
		end else if (rx_in.receive_active_flag) begin
			evt_code = URC_EVT_ACTIVE;
		end else if (host_mode && rx_in.host_disconnect_flag) begin
			evt_code = URC_EVT_DISC;
		end else begin
			evt_code = URC_EVT_NONE;
		end
	end

	assign bv_edge = (ctrl_q[URC_CTRL_BV_RISE] && ana_q.b_sess_vld && !bv_prev_q)
		|| (ctrl_q[URC_CTRL_BV_FALL] && !ana_q.b_sess_vld && bv_prev_q);

	// line state passes through; its meaning is set by mode outside
	assign cur_byte = {alt_pend_q, ana_q.id_pin, evt_code, vbus_code, ana_q.line_state};

	// ------------------------------------------------------------
	// link side state machine
	// ------------------------------------------------------------
	urc_state_t state_q;
	logic [7:0] sent_q;
	logic       byte_change;

	// one compare over the whole byte merges simultaneous changes
	assign byte_change = (cur_byte != sent_q) || alt_pend_q;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			bv_prev_q  <= 1'b0;
			alt_pend_q <= 1'b0;
		end else if (clk_en) begin
			bv_prev_q <= ana_q.b_sess_vld;
			if (bv_edge) begin
				alt_pend_q <= 1'b1;
			end else if (alt_pend_q && (state_q == URC_ST_SEND
				|| (state_q == URC_ST_DATA && rx_in.receive_active_flag))) begin
				// a byte carrying the bit goes out this cycle, in or out of a packet
				alt_pend_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_q     <= URC_ST_IDLE;
			sent_q      <= 8'h00;
			last_byte_q <= 8'h00;
			dir         <= 1'b0;
			nxt         <= 1'b0;
			data_out    <= 8'h00;
			data_oe     <= 1'b0;
		end else if (clk_en) begin
			case (state_q)
				URC_ST_IDLE: begin
					nxt     <= 1'b0;
					data_oe <= 1'b0;
					if (rx_in.receive_active_flag && !rx_in.receive_error_flag) begin
						dir     <= 1'b1;
						nxt     <= 1'b1;
						state_q <= URC_ST_DATA;
					end else if (byte_change) begin
						dir     <= 1'b1;
						state_q <= URC_ST_TURN;
					end else begin
						dir <= 1'b0;
					end
				end
				URC_ST_TURN: begin
					// turnaround cycle: bus owned, nothing driven yet
					state_q <= URC_ST_SEND;
				end
				URC_ST_SEND: begin
					data_out    <= cur_byte;
					data_oe     <= 1'b1;
					nxt         <= 1'b0;
					sent_q      <= cur_byte;
					last_byte_q <= cur_byte;
					if (rx_in.receive_active_flag) begin
						state_q <= URC_ST_DATA;
					end else begin
						state_q <= URC_ST_IDLE;
					end
				end
				URC_ST_DATA: begin
					data_oe <= 1'b1;
					if (!rx_in.receive_active_flag) begin
						// end of packet: drop dir, nxt and data_oe together at once, no closing byte is sent
						dir     <= 1'b0;
						nxt     <= 1'b0;
						data_oe <= 1'b0;
						state_q <= byte_change ? URC_ST_IDLE : URC_ST_IDLE;
					end else if (cur_byte != sent_q || alt_pend_q) begin
						// status slipped between data with nxt low
						data_out    <= cur_byte;
						nxt         <= 1'b0;
						sent_q      <= cur_byte;
						last_byte_q <= cur_byte;
					end else if (rx_in.rx_data_valid && !rx_in.receive_error_flag) begin
						// a failed packet forwards no more data, nxt stays low
						data_out <= rx_in.rx_data;
						nxt      <= 1'b1;
					end else begin
						nxt <= 1'b0;
					end
				end
				default: state_q <= URC_ST_IDLE;
			endcase
		end
	end

	// event sources for the interrupt status
	always_comb begin
		irq_set = '0;
		irq_set[URC_IRQ_SENT]  = (state_q == URC_ST_SEND);
		irq_set[URC_IRQ_ALT]   = bv_edge;
		irq_set[URC_IRQ_RXERR] = rx_in.receive_error_flag;
	end

endmodule : urc_status

// [verification/urc_status_monitor.sv]
module urc_status_monitor
	import urc_pkg::*;
(
	input wire logic        clk,
	input wire logic        rst_n,
	input wire urc_analog_t analog_in,
	input wire urc_rx_t     rx_in,
	input wire logic        dir,
	input wire logic        nxt,
	input wire logic [7:0]  data_out,
	input wire logic        data_oe,
	input wire logic        hreadyout,
	input wire logic        hresp
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----
	// link side and bus checks
	// ----
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	urc_analog_t ana_q;
	logic [3:0]  age_q;  // cycles since any analog input moved
	logic [3:0]  bage_q; // cycles since the bus-valid input moved
	logic        stat;
	logic [1:0]  vb;

	// ages saturate; older bytes in flight may still carry stale fields
	always_ff @(posedge clk) begin
		ana_q <= analog_in;
		if (!rst_n || analog_in != ana_q)
			age_q <= 4'h0;
		else if (age_q != 4'hF)
			age_q <= age_q + 4'h1;
		if (!rst_n || analog_in.b_sess_vld != ana_q.b_sess_vld)
			bage_q <= 4'h0;
		else if (bage_q != 4'hF)
			bage_q <= bage_q + 4'h1;
	end

	assign stat = dir && data_oe && !nxt;
	assign vb   = analog_in.a_side_bus_valid_flag ? 2'h3 :
		analog_in.sess_vld ? 2'h2 : {1'b0, !analog_in.sess_end};

	chk_oe_dir: assert property (data_oe |-> dir)
		else $error("data bus driven without dir");
	chk_turn_around: assert property ($rose(dir) && !nxt |-> !data_oe ##1 !data_oe ##1 stat)
		else $error("status byte not after one turnaround");
	chk_vbus_code: assert property (stat && age_q > 4'h8 |-> data_out[3:2] == vb)
		else $error("bus voltage code wrong");
	chk_line_id: assert property (stat && age_q > 4'h8 |-> data_out[1:0] == analog_in.line_state
		&& data_out[6] == analog_in.id_pin)
		else $error("line or id field wrong");
	chk_alt_cause: assert property (stat && data_out[7] |-> bage_q < 4'hC)
		else $error("alternate bit without bus-valid edge");
	chk_rx_start: assert property ($rose(rx_in.receive_active_flag) && !dir |-> ##[1:3] (dir && nxt))
		else $error("packet start not shown");
	chk_err_byte: assert property ($rose(rx_in.receive_error_flag) && rx_in.receive_active_flag
		|-> ##[1:6] (stat && data_out[5:4] == 2'h3))
		else $error("receive error byte missing");
	chk_rx_end: assert property ($fell(rx_in.receive_active_flag) |-> ##[1:4] !dir)
		else $error("dir held after receive end");
	chk_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus slave stalled or erred");

	cover property (stat && data_out[7]);
	cover property (dir && nxt);
	cover property (stat && data_out[5:4] == 2'h3);
endmodule : urc_status_monitor

bind urc_status urc_status_monitor i_mon (
	.clk(clk),
	.rst_n(rst_n),
	.analog_in(analog_in),
	.rx_in(rx_in),
	.dir(dir),
	.nxt(nxt),
	.data_out(data_out),
	.data_oe(data_oe),
	.hreadyout(hreadyout),
	.hresp(hresp)
);

// [verification/urc_link_model.sv]
module urc_link_model
	import urc_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       dir,
	input  wire logic       nxt,
	input  wire logic       data_oe,
	input  wire logic [7:0] data_out,
	output logic [7:0]      last_status,
	output int              n_good
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----
	// passive receiver of the link
	// ----
	logic       dir_q;
	logic [7:0] n_data_q; // data bytes of the packet in flight

	// a turnaround cycle carries nothing, so dir must be one cycle old
	always_ff @(posedge clk) begin
		dir_q <= dir;
		if (!rst_n) begin
			last_status <= 8'h00;
			n_data_q    <= 8'h00;
			n_good      <= 0;
		end else if (dir && dir_q && data_oe && !nxt) begin
			last_status <= data_out;
			if (data_out[5:4] == 2'h3)
				n_data_q <= 8'h00;
		end else if (dir && nxt && data_oe) begin
			n_data_q <= n_data_q + 8'h01;
		end else if (!dir && dir_q && n_data_q != 8'h00) begin
			n_good   <= n_good + 1;
			n_data_q <= 8'h00;
		end
	end
endmodule : urc_link_model

// [verification/tb_top.sv]
module tb_top
	import urc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	// ----
	// bench
	// ----
	logic        clk;
	logic        rst_n;
	urc_analog_t ana;
	urc_rx_t     rx;
	logic        dir, nxt, oe, idv, hsel, hwrite, hrdy, hresp, irq;
	logic [7:0]  dout, haddr, last;
	logic [1:0]  htrans;
	logic [31:0] hwdata, hrdata, rd, seed;
	int          fails, n_compared, cyc, n_good, i;

	urc_status #(.ID_WAIT_CYC(20)) i_dut (.clk(clk), .rst_n(rst_n), .clk_en(1'b1),
		.analog_in(ana), .rx_in(rx), .dir(dir), .nxt(nxt), .data_out(dout), .data_oe(oe),
		.id_valid(idv), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hrdy), .hrdata(hrdata), .hreadyout(hrdy),
		.hresp(hresp), .irq(irq));
	urc_link_model i_link (.clk(clk), .rst_n(rst_n), .dir(dir), .nxt(nxt), .data_oe(oe),
		.data_out(dout), .last_status(last), .n_good(n_good));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task cmp(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			fails++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : cmp

	task test_done;
		$display("compared=%0d fails=%0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : test_done

	// single word transfer; waits on hready, never on a fixed count
	task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		haddr  <= a;
		hwrite <= w;
		do @(posedge clk); while (hrdy !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hrdy !== 1'b1);
		rd = hrdata;
	endtask : ahb

	task wait_byte(input logic [7:0] e);
		for (int k = 0; k < 40 && last !== e; k++) @(posedge clk);
		cmp({24'h0, last}, {24'h0, e});
	endtask : wait_byte

	function logic [7:0] exp_byte(input logic pd, input logic alt);
		logic [1:0] v;
		logic [1:0] e;
		v = ana.a_side_bus_valid_flag ? 2'h3 : ana.sess_vld ? 2'h2 : {1'b0, !ana.sess_end};
		e = rx.receive_active_flag ? {rx.receive_error_flag, 1'b1} :
			{pd & rx.host_disconnect_flag, 1'b0};
		return {alt, ana.id_pin, e, v, ana.line_state};
	endfunction : exp_byte

	function logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr

	// hang guard, well above the expected few hundred cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 8000) begin
			fails++;
			test_done;
		end
	end

	initial begin
		rst_n  = 1'b0;
		ana    = '0;
		rx     = '0;
		hsel   = 1'b0;
		htrans = 2'h0;
		haddr  = 8'h00;
		hwrite = 1'b0;
		hwdata = 32'h0;
		seed   = 32'h19CB;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		ahb(1'b1, 8'h14, 32'hFFFFFFFF);
		ahb(1'b0, 8'h14, 32'h0);
		cmp(rd, 32'h0);
		ahb(1'b0, URC_OFS_CTRL, 32'h0);
		cmp(rd, 32'h0);
		wait_byte(exp_byte(1'b0, 1'b0));
		$display("end reset");
		for (i = 0; i < 4; i++) begin
			ana.sess_end              <= (i != 1);
			ana.sess_vld              <= (i >= 2);
			ana.a_side_bus_valid_flag <= (i == 3);
			@(posedge clk);
			wait_byte(exp_byte(1'b0, 1'b0));
		end
		for (i = 0; i < 16; i++) begin
			seed = lfsr(seed);
			ana.line_state            <= seed[1:0];
			ana.sess_end              <= seed[2];
			ana.sess_vld              <= seed[3];
			ana.a_side_bus_valid_flag <= seed[4];
			ana.id_pin                <= seed[5];
			@(posedge clk);
			wait_byte(exp_byte(1'b0, 1'b0));
		end
		$display("end fields");
		ahb(1'b1, URC_OFS_CTRL, 32'h2);
		ahb(1'b1, URC_OFS_MASK, 32'h2);
		ana.b_sess_vld <= 1'b1;
		@(posedge clk);
		wait_byte(exp_byte(1'b0, 1'b1));
		wait_byte(exp_byte(1'b0, 1'b0));
		repeat (3) @(posedge clk);
		cmp({31'h0, irq}, 32'h1);
		ahb(1'b1, URC_OFS_IRQ, 32'h7);
		ana.b_sess_vld <= 1'b0;
		repeat (12) @(posedge clk);
		cmp({31'h0, irq}, 32'h0);
		ahb(1'b0, URC_OFS_IRQ, 32'h0);
		cmp(rd & 32'h2, 32'h0);
		$display("end alternate");
		rx.host_disconnect_flag <= 1'b1;
		repeat (10) @(posedge clk);
		cmp({24'h0, last}, {24'h0, exp_byte(1'b0, 1'b0)});
		ahb(1'b1, URC_OFS_CTRL, 32'h18);
		@(posedge clk);
		wait_byte(exp_byte(1'b1, 1'b0));
		rx.receive_active_flag <= 1'b1;
		rx.rx_data_valid       <= 1'b1;
		rx.rx_data             <= seed[7:0];
		for (i = 0; i < 10 && dir !== 1'b1; i++) @(posedge clk);
		cmp({30'h0, dir, nxt}, 32'h3);
		repeat (3) @(posedge clk);
		rx.receive_error_flag <= 1'b1;
		@(posedge clk);
		wait_byte(exp_byte(1'b1, 1'b0));
		rx.receive_active_flag <= 1'b0;
		rx.receive_error_flag  <= 1'b0;
		rx.rx_data_valid       <= 1'b0;
		@(posedge clk);
		wait_byte(exp_byte(1'b1, 1'b0));
		cmp(n_good, 32'h0);
		rx.receive_active_flag <= 1'b1;
		rx.rx_data_valid       <= 1'b1;
		repeat (6) @(posedge clk);
		rx.receive_active_flag <= 1'b0;
		rx.rx_data_valid       <= 1'b0;
		repeat (10) @(posedge clk);
		cmp(n_good, 32'h1);
		$display("end receive");
		ahb(1'b1, URC_OFS_CTRL, 32'h19);
		repeat (8) @(posedge clk);
		cmp({31'h0, idv}, 32'h0);
		repeat (20) @(posedge clk);
		cmp({31'h0, idv}, 32'h1);
		ahb(1'b0, URC_OFS_STATUS, 32'h0);
		cmp(rd, {26'h0, 1'b1, ana.id_pin, ana.b_sess_vld, ana.a_side_bus_valid_flag,
			ana.sess_vld, ana.sess_end});
		$display("end id");
		test_done;
	end
endmodule : tb_top
